// file: acr_config_regs.sv
// configuration registers two and three with field decoding
// What this block does
// - the rate code decodes per mode to normal, quarter or double rates.
// - rates hold at the reference clock; only the scaled rate output scales with other clocks.
// - bits 7:6 pick internal, dedicated, shared-input or supply reference.
// - bits 5:4 pick no, combined, 50 Hz or 60 Hz line rejection.
// - rejection applies only at 20 SPS normal or 5 SPS duty-cycle.
// - switch bit 0 keeps switch open, 1 closes on begin and opens on sleep.
// - bits 2:0 set the excitation current, code 001 unused.
// - bits 7:5 of routing route the first source, 111 unused.
// - bits 4:2 of routing route the second source the same way.
// - ready mode 1 signals data ready on both pins, 0 only dedicated.
// - mode field selects normal, duty-cycle, turbo, 11 unused.
`timescale 1ns/1ps
`include "acr_defs.svh"
module acr_config_regs
	import acr_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic wr_en_i,
	input wire logic [1:0] addr_i,
	input wire logic [7:0] wr_data_i,
	output logic [7:0] rd_data_o,
	input wire logic [2:0] data_rate_select_i,
	input wire logic [1:0] mode_i,
	input wire logic ext_clk_sel_i,
	input wire logic [15:0] ext_clk_khz_i,
	input wire logic begin_cmd_i,
	input wire logic sleep_cmd_i,
	input wire logic data_ready_i,
	output logic [15:0] rate_milli_sps_o,
	output logic rate_valid_o,
	output logic [31:0] scaled_rate_milli_sps_o,
	output logic [1:0] ref_select_o,
	output logic [1:0] reject_coef_o,
	output logic reject_active_o,
	output logic low_side_switch_ctl_o,
	output logic [10:0] excitation_current_level_o,
	output logic [6:0] first_source_route_o,
	output logic [6:0] second_source_route_o,
	output logic dedicated_ready_pin_o,
	output logic shared_output_ready_pin_o
);
	logic [7:0] ref_filt_cfg;
	logic [7:0] routing_cfg;
	acr_sw_t sw_state;

	// base normal-mode rate in SPS per code, 0 when unused
	function automatic logic [15:0] base_rate(input logic [2:0] code);
		case (code)
			3'h0: base_rate = 16'h0014;
			3'h1: base_rate = 16'h002D;
			3'h2: base_rate = 16'h005A;
			3'h3: base_rate = 16'h00AF;
			3'h4: base_rate = 16'h014A;
			3'h5: base_rate = 16'h0258;
			3'h6: base_rate = 16'h03E8;
			default: base_rate = 16'h0000;
		endcase
	endfunction : base_rate

	// one-hot route decode, unused and disabled give no connection
	function automatic logic [6:0] route_dec(input logic [2:0] code);
		case (code)
			3'h1: route_dec = 7'h01;
			3'h2: route_dec = 7'h02;
			3'h3: route_dec = 7'h04;
			3'h4: route_dec = 7'h08;
			3'h5: route_dec = 7'h10;
			3'h6: route_dec = 7'h20;
			default: route_dec = 7'h00;
		endcase
	endfunction : route_dec

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ref_filt_cfg <= `ACR_RESET_VAL;
			routing_cfg <= `ACR_RESET_VAL;
		end else if (wr_en_i) begin
			if (addr_i == `ACR_OFF_REF_FILT) begin
				ref_filt_cfg <= wr_data_i;
			end
			if (addr_i == `ACR_OFF_ROUTING) begin
				routing_cfg <= wr_data_i;
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rd_data_o <= 8'h00;
		end else begin
			case (addr_i)
				`ACR_OFF_REF_FILT: rd_data_o <= ref_filt_cfg;
				`ACR_OFF_ROUTING: rd_data_o <= routing_cfg;
				default: rd_data_o <= 8'h00;
			endcase
		end
	end

	// rate in milli-SPS: duty is quarter, turbo double
	logic [15:0] base;
	logic [31:0] rate_ms;
	logic rate_ok;
	always_comb begin
		base = base_rate(data_rate_select_i);
		rate_ok = (data_rate_select_i != 3'h7);
		case (acr_mode_t'(mode_i))
			ACR_MODE_NORMAL: rate_ms = 32'(base) * 32'd1000;
			ACR_MODE_DUTY: begin
				rate_ms = 32'(base) * 32'd250;
				// code 011 runs at 44 SPS, not a strict quarter
				if (data_rate_select_i == 3'h3) begin
					rate_ms = 32'd44000;
				end
			end
			ACR_MODE_TURBO: rate_ms = 32'(base) * 32'd2000;
			default: begin
				rate_ms = 32'h0;
				rate_ok = 1'b0;
			end
		endcase
	end

	logic [47:0] scaled;
	always_comb begin
		if (ext_clk_sel_i) begin
			scaled = (48'(rate_ms) * 48'(ext_clk_khz_i)) /
				48'(`ACR_RATE_REF_KHZ);
		end else begin
			scaled = 48'(rate_ms);
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rate_milli_sps_o <= 16'h0000;
			rate_valid_o <= 1'b0;
			scaled_rate_milli_sps_o <= 32'h0;
		end else begin
			rate_milli_sps_o <= rate_ms[15:0] == 16'h0 ? 16'h0 :
				16'(rate_ms / 32'd1000);
			rate_valid_o <= rate_ok;
			scaled_rate_milli_sps_o <= scaled[31:0];
		end
	end

	// switch follows begin/sleep only when enabled
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sw_state <= ACR_SW_OPEN;
		end else if (!ref_filt_cfg[`ACR_SW_BIT]) begin
			sw_state <= ACR_SW_OPEN;
		end else if (sleep_cmd_i) begin
			sw_state <= ACR_SW_OPEN;
		end else if (begin_cmd_i) begin
			sw_state <= ACR_SW_CLOSED;
		end
	end

	logic [10:0] level_ua;
	always_comb begin
		case (ref_filt_cfg[`ACR_LVL_MSB:`ACR_LVL_LSB])
			3'h2: level_ua = 11'd50;
			3'h3: level_ua = 11'd100;
			3'h4: level_ua = 11'd250;
			3'h5: level_ua = 11'd500;
			3'h6: level_ua = 11'd1000;
			3'h7: level_ua = 11'd1500;
			default: level_ua = 11'd0;
		endcase
	end

	logic rej_ok;
	assign rej_ok = (data_rate_select_i == 3'h0) &&
		((mode_i == 2'h0) || (mode_i == 2'h1));

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ref_select_o <= 2'h0;
			reject_coef_o <= 2'h0;
			reject_active_o <= 1'b0;
			low_side_switch_ctl_o <= 1'b0;
			excitation_current_level_o <= 11'h000;
			first_source_route_o <= 7'h00;
			second_source_route_o <= 7'h00;
		end else begin
			ref_select_o <= ref_filt_cfg[`ACR_REF_MSB:`ACR_REF_LSB];
			reject_coef_o <= rej_ok ?
				ref_filt_cfg[`ACR_REJ_MSB:`ACR_REJ_LSB] : 2'h0;
			reject_active_o <= rej_ok &&
				(ref_filt_cfg[`ACR_REJ_MSB:`ACR_REJ_LSB] != 2'h0);
			low_side_switch_ctl_o <= (sw_state == ACR_SW_CLOSED);
			excitation_current_level_o <= level_ua;
			first_source_route_o <=
				route_dec(routing_cfg[`ACR_R1_MSB:`ACR_R1_LSB]);
			second_source_route_o <=
				route_dec(routing_cfg[`ACR_R2_MSB:`ACR_R2_LSB]);
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			dedicated_ready_pin_o <= 1'b0;
			shared_output_ready_pin_o <= 1'b0;
		end else begin
			dedicated_ready_pin_o <= data_ready_i;
			shared_output_ready_pin_o <= data_ready_i &&
				routing_cfg[`ACR_RDY_BIT];
		end
	end

	property p_switch_open;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		// state register plus output register: two edges of lag
		!ref_filt_cfg[`ACR_SW_BIT] |=> ##1 !low_side_switch_ctl_o;
	endproperty
	a_switch_open: assert property (p_switch_open)
		else $error("switch closed while disabled");

	sequence s_begin_enabled;
		ref_filt_cfg[`ACR_SW_BIT] && begin_cmd_i && !sleep_cmd_i;
	endsequence
	property p_switch_close;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		s_begin_enabled ##1 ref_filt_cfg[`ACR_SW_BIT] |=>
			low_side_switch_ctl_o;
	endproperty
	a_switch_close: assert property (p_switch_close)
		else $error("switch did not close on begin");

	property p_sleep_opens;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		sleep_cmd_i |=> ##1 !low_side_switch_ctl_o;
	endproperty
	a_sleep_opens: assert property (p_sleep_opens)
		else $error("switch not opened by sleep");

	property p_shared_ready;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		!routing_cfg[`ACR_RDY_BIT] |=> !shared_output_ready_pin_o;
	endproperty
	a_shared_ready: assert property (p_shared_ready)
		else $error("shared pin signalled in dedicated mode");

	property p_dedicated_ready;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		data_ready_i |=> dedicated_ready_pin_o;
	endproperty
	a_dedicated_ready: assert property (p_dedicated_ready)
		else $error("dedicated pin missed data ready");

	property p_reject_gate;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		!rej_ok |=> reject_coef_o == 2'h0;
	endproperty
	a_reject_gate: assert property (p_reject_gate)
		else $error("rejection applied at wrong rate");

	property p_readback;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(wr_en_i && addr_i == `ACR_OFF_ROUTING) ##1
			(addr_i == `ACR_OFF_ROUTING && !wr_en_i) |=>
			rd_data_o == $past(wr_data_i, 2);
	endproperty
	a_readback: assert property (p_readback)
		else $error("routing readback mismatch");

	property p_route_unused;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		routing_cfg[`ACR_R1_MSB:`ACR_R1_LSB] == 3'h7 |=>
			first_source_route_o == 7'h00;
	endproperty
	a_route_unused: assert property (p_route_unused)
		else $error("unused route code connected");

	property p_level_unused;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		ref_filt_cfg[`ACR_LVL_MSB:`ACR_LVL_LSB] == 3'h1 |=>
			excitation_current_level_o == 11'd0;
	endproperty
	a_level_unused: assert property (p_level_unused)
		else $error("unused current code not off");

	property p_turbo_rate;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(mode_i == 2'h2 && data_rate_select_i == 3'h0) |=>
			rate_milli_sps_o == 16'd40;
	endproperty
	a_turbo_rate: assert property (p_turbo_rate)
		else $error("turbo rate wrong");

	property p_duty_rate;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(mode_i == 2'h1 && data_rate_select_i == 3'h3) |=>
			rate_milli_sps_o == 16'd44;
	endproperty
	a_duty_rate: assert property (p_duty_rate)
		else $error("duty rate wrong");

	property p_route2_unused;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		routing_cfg[`ACR_R2_MSB:`ACR_R2_LSB] == 3'h7 |=>
			second_source_route_o == 7'h00;
	endproperty
	a_route2_unused: assert property (p_route2_unused)
		else $error("unused second route code connected");
endmodule : acr_config_regs

// file: acr_defs.svh
// constants for the converter configuration register block
`ifndef ACR_DEFS_SVH
`define ACR_DEFS_SVH
`define ACR_OFF_REF_FILT 2'h2
`define ACR_OFF_ROUTING 2'h3
`define ACR_RESET_VAL 8'h00
`define ACR_REF_MSB 7
`define ACR_REF_LSB 6
`define ACR_REJ_MSB 5
`define ACR_REJ_LSB 4
`define ACR_SW_BIT 3
`define ACR_LVL_MSB 2
`define ACR_LVL_LSB 0
`define ACR_R1_MSB 7
`define ACR_R1_LSB 5
`define ACR_R2_MSB 4
`define ACR_R2_LSB 2
`define ACR_RDY_BIT 1
`define ACR_RATE_REF_KHZ 32'd4096
`endif

// file: acr_pkg.sv
// types for the converter configuration register block
package acr_pkg;
	typedef enum logic [1:0] {
		ACR_MODE_NORMAL,
		ACR_MODE_DUTY,
		ACR_MODE_TURBO,
		ACR_MODE_UNUSED
	} acr_mode_t;
	typedef enum logic {
		ACR_SW_OPEN,
		ACR_SW_CLOSED
	} acr_sw_t;
endpackage : acr_pkg

// file: acr_host_model.sv
// host side model that writes and reads the config registers
`timescale 1ns/1ps
module acr_host_model (
	input wire logic core_clk_i,
	input wire logic [7:0] rd_data_i,
	output logic wr_en_o,
	output logic [1:0] addr_o,
	output logic [7:0] wr_data_o
);
	initial begin
		wr_en_o = 1'b0;
		addr_o = 2'h0;
		wr_data_o = 8'h00;
	end
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		logic [7:0] v;
		v = (a == 2'h3) ? {d[7:1], 1'b0} : d;
		@(posedge core_clk_i);
		wr_en_o <= 1'b1;
		addr_o <= a;
		wr_data_o <= v;
		@(posedge core_clk_i);
		wr_en_o <= 1'b0;
		wr_data_o <= ~v;
	endtask : wr
	task automatic rd(input logic [1:0] a, output logic [7:0] d);
		@(posedge core_clk_i);
		addr_o <= a;
		repeat (2) @(posedge core_clk_i);
		d = rd_data_i;
	endtask : rd
endmodule : acr_host_model

// file: testbench.sv
// self-checking bench for the config register block
`timescale 1ns/1ps
module testbench;
	logic core_clk_i, rst_n_i, wr_en, begin_cmd, sleep_cmd, rdy, xs;
	logic [1:0] addr, md, refs, coef;
	logic [2:0] dr;
	logic [7:0] wd, rd, d2, d3, m3, t;
	logic [15:0] khz, rate;
	logic [31:0] srate;
	logic [10:0] lvl;
	logic [6:0] r1, r2;
	logic vld, sw, ded, shr, sws, ract;
	int err_total, tests_run, cyc, i, b, seed;
	int rt[21] = '{20000, 45000, 90000, 175000, 330000, 600000, 1000000,
		5000, 11250, 22500, 44000, 82500, 150000, 250000,
		40000, 90000, 180000, 350000, 660000, 1200000, 2000000};
	int ua[8] = '{0, 0, 50, 100, 250, 500, 1000, 1500};
	acr_host_model host (.core_clk_i(core_clk_i), .rd_data_i(rd),
		.wr_en_o(wr_en), .addr_o(addr), .wr_data_o(wd));
	acr_config_regs dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
		.wr_en_i(wr_en), .addr_i(addr), .wr_data_i(wd), .rd_data_o(rd),
		.data_rate_select_i(dr), .mode_i(md), .ext_clk_sel_i(xs),
		.ext_clk_khz_i(khz), .begin_cmd_i(begin_cmd),
		.sleep_cmd_i(sleep_cmd), .data_ready_i(rdy),
		.rate_milli_sps_o(rate), .rate_valid_o(vld),
		.scaled_rate_milli_sps_o(srate), .ref_select_o(refs),
		.reject_coef_o(coef), .reject_active_o(ract),
		.low_side_switch_ctl_o(sw), .excitation_current_level_o(lvl),
		.first_source_route_o(r1), .second_source_route_o(r2),
		.dedicated_ready_pin_o(ded), .shared_output_ready_pin_o(shr));
	initial begin
		core_clk_i = 1'b0;
		forever #10 core_clk_i = ~core_clk_i;
	end
	function automatic logic [6:0] hot(input logic [2:0] c);
		return (c != 3'h0 && c != 3'h7) ? 7'h01 << (c - 3'h1) : 7'h00;
	endfunction : hot
	task automatic final_report();
		if (err_total == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : final_report
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task automatic pulse(input logic bg, input logic sl);
		@(posedge core_clk_i);
		begin_cmd <= bg;
		sleep_cmd <= sl;
		@(posedge core_clk_i);
		begin_cmd <= 1'b0;
		sleep_cmd <= 1'b0;
		repeat (3) @(posedge core_clk_i);
	endtask : pulse
	always @(posedge core_clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			err_total++;
			final_report();
		end
	end
	initial begin
		seed = 32'hc816faa3;
		err_total = 0;
		tests_run = 0;
		cyc = 0;
		sws = 1'b0;
		rst_n_i = 1'b0;
		begin_cmd = 1'b0;
		sleep_cmd = 1'b0;
		rdy = 1'b0;
		xs = 1'b0;
		md = 2'h0;
		dr = 3'h0;
		khz = 16'h1000;
		repeat (12) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		for (i = 1; i < 4; i++) begin
			host.rd(i[1:0], t);
			chk(t, 0);
		end
		for (i = 0; i < 32; i++) begin
			d2 = 8'($random(seed));
			d3 = 8'($random(seed));
			m3 = {d3[7:1], 1'b0};
			@(posedge core_clk_i);
			dr <= i[2:0];
			md <= i[4:3];
			xs <= 1'($random(seed));
			rdy <= 1'($random(seed));
			khz <= 16'h2000;
			host.wr(2'h2, d2);
			host.wr(2'h3, d3);
			sws = sws & d2[3];
			repeat (3) @(posedge core_clk_i);
			chk(sw, sws);
			host.rd(2'h2, t);
			chk(t, d2);
			host.rd(2'h3, t);
			chk(t, m3);
			chk(refs, d2[7:6]);
			chk(coef, (i < 16 && i % 8 == 0) ? d2[5:4] : 2'h0);
			chk(ract, i < 16 && i % 8 == 0 && d2[5:4] != 2'h0);
			chk(lvl, ua[d2[2:0]]);
			chk(r1, hot(m3[7:5]));
			chk(r2, hot(m3[4:2]));
			chk(ded, rdy);
			chk(shr, rdy & m3[1]);
			chk(vld, i < 24 && i % 8 != 7);
			if (i < 24 && i % 8 != 7) begin
				b = rt[(i / 8) * 7 + i % 8];
				chk(rate, b / 1000);
				chk(srate, xs ? b * 2 : b);
			end
			pulse(1'b1, 1'b0);
			sws = d2[3];
			chk(sw, sws);
			if (d3[0]) begin
				pulse(1'b1, 1'b1);
				sws = 1'b0;
				chk(sw, sws);
			end
		end
		// mid-run reset must bring both registers back to zero
		@(posedge core_clk_i);
		rst_n_i <= 1'b0;
		repeat (2) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		for (i = 2; i < 4; i++) begin
			host.rd(i[1:0], t);
			chk(t, 0);
		end
		chk(sw, 1'b0);
		chk(r1, 7'h00);
		chk(r2, 7'h00);
		final_report();
	end
endmodule : testbench
